// [pkg/fao_pkg.sv]
// ==========================================================================
// Shared constants of the fault alarm output block
package fao_pkg;

  // ========================================================================
  // Sizes
  localparam int unsigned N_OUT      = 3;
  localparam int unsigned N_SRC      = 7;
  localparam int unsigned N_DLY      = 4;
  localparam int unsigned HW_FAULT_W = 8;
  localparam int unsigned N_PS       = 2;
  localparam int unsigned TIME_W     = 24;
  localparam int unsigned DSEC_W     = 19;
  localparam int unsigned SECCNT_W   = 25;

  // ========================================================================
  // Source bit positions inside an enable register
  localparam int unsigned SRC_HW        = 0;
  localparam int unsigned SRC_PS        = 1;
  localparam int unsigned SRC_LOCK_ERR  = 2;
  localparam int unsigned SRC_LOCK_WARN = 3;
  localparam int unsigned SRC_TIME_ERR  = 4;
  localparam int unsigned SRC_TIME_WARN = 5;
  localparam int unsigned SRC_ALARM_TM  = 6;

  // Delay slot numbers
  localparam int unsigned DLY_LOCK_ERR  = 0;
  localparam int unsigned DLY_LOCK_WARN = 1;
  localparam int unsigned DLY_TIME_ERR  = 2;
  localparam int unsigned DLY_TIME_WARN = 3;

  // ========================================================================
  // HH:MM:SS field positions, two BCD digits each
  localparam int unsigned HH_LSB = 16;
  localparam int unsigned MM_LSB = 8;
  localparam int unsigned SS_LSB = 0;

  // ========================================================================
  // Register byte offsets
  localparam logic [7:0] OFF_EN0       = 8'h00;
  localparam logic [7:0] OFF_EN1       = 8'h04;
  localparam logic [7:0] OFF_EN2       = 8'h08;
  localparam logic [7:0] OFF_DLY0      = 8'h0c;
  localparam logic [7:0] OFF_DLY1      = 8'h10;
  localparam logic [7:0] OFF_DLY2      = 8'h14;
  localparam logic [7:0] OFF_DLY3      = 8'h18;
  localparam logic [7:0] OFF_ALARM_TM  = 8'h1c;
  localparam logic [7:0] OFF_STATUS    = 8'h20;
  localparam logic [7:0] OFF_IRQ_STS   = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h28;

  // Reset values
  localparam logic [N_SRC-1:0]  RST_EN       = 7'h00;
  localparam logic [TIME_W-1:0] RST_DLY      = 24'h000010;
  localparam logic [TIME_W-1:0] RST_ALARM_TM = 24'h000000;
  localparam logic [N_OUT-1:0]  RST_MASK     = 3'h0;

  // ========================================================================
  // Timing
  localparam int unsigned CLK_HZ     = 25_000_000;
  localparam int unsigned ONE_SEC_S  = 1;
  localparam int unsigned SEC_CYCLES = ONE_SEC_S * CLK_HZ;

endpackage : fao_pkg

// [pkg/fao_dly_if.sv]
// ==========================================================================
// Link between the alarm core and one delay qualifier
interface fao_dly_if;
  logic                        cond;
  logic                        sec_tick;
  logic [fao_pkg::TIME_W-1:0]  delay_hms;
  logic                        qual;

  modport ctrl (output cond, output sec_tick, output delay_hms, input qual);
  modport qual_side (input cond, input sec_tick, input delay_hms, output qual);
endinterface : fao_dly_if

// [rtl/fao_delay_qual.sv]
// ==========================================================================
// Holds off one condition until it has persisted for its delay
module fao_delay_qual
(
  input  wire logic  pclk,
  input  wire logic  presetn,
  fao_dly_if.qual_side dly
);

  logic [fao_pkg::DSEC_W-1:0] limit_s;
  logic [fao_pkg::DSEC_W-1:0] cnt_q;
  logic                       qual_q;

  function automatic logic [fao_pkg::DSEC_W-1:0] bcd2(input logic [7:0] b);
    bcd2 = fao_pkg::DSEC_W'(b[7:4]) * fao_pkg::DSEC_W'(10) + fao_pkg::DSEC_W'(b[3:0]);
  endfunction : bcd2

  // Ticks arrive at an arbitrary phase, so one extra tick guarantees the full delay
  always_comb
  begin
    limit_s = bcd2(dly.delay_hms[fao_pkg::HH_LSB +: 8]) * fao_pkg::DSEC_W'(3600)
            + bcd2(dly.delay_hms[fao_pkg::MM_LSB +: 8]) * fao_pkg::DSEC_W'(60)
            + bcd2(dly.delay_hms[fao_pkg::SS_LSB +: 8]);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= '0;
    else if (!dly.cond)
      cnt_q <= '0;
    else if (dly.sec_tick && cnt_q <= limit_s)
      cnt_q <= cnt_q + fao_pkg::DSEC_W'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      qual_q <= 1'b0;
    else
      qual_q <= dly.cond && (limit_s == '0 || cnt_q > limit_s);
  end

  assign dly.qual = qual_q;

endmodule : fao_delay_qual

// [rtl/fao_top.sv]
// ==========================================================================
// Overview of operation
// - Three alarm outputs, each with own enables
// - Hardware fault source: any diagnosed fault
// - Supply fault source: either supply module faulty
// - Lock error source: reference lock lost
// - Lock warning source: near end of tune range
// - Time error source: selected time input invalid
// - Time warning source: time input fails quality
// - Alarm time: one second pulse on match
// - Four separate delays for lock and time
// - Alarm only after condition persists full delay
// - Each delay resets to ten seconds
// - One delay setting shared by all outputs
// - Delays held as HH:MM:SS, one-second resolution
module fao_top
#(
  parameter int unsigned SEC_CYCLES = fao_pkg::SEC_CYCLES
)
(
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [7:0]                        paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic [fao_pkg::HW_FAULT_W-1:0]    hw_fault,
  input  wire logic [fao_pkg::N_PS-1:0]          ps_fault,
  input  wire logic                              lock_lost,
  input  wire logic                              lock_near_loss,
  input  wire logic                              time_invalid,
  input  wire logic                              time_quality_fail,
  input  wire logic [fao_pkg::TIME_W-1:0]        program_time,
  output logic      [fao_pkg::N_OUT-1:0]         aux_alarm_port,
  output logic                                   irq
);

  localparam int unsigned N_PIN = fao_pkg::HW_FAULT_W + fao_pkg::N_PS + 4;

  // ========================================================================
  // Pin synchronisers
  logic [N_PIN-1:0] pin_meta_q;
  logic [N_PIN-1:0] pin_sync_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end
    else
    begin
      pin_meta_q <= {hw_fault, ps_fault, lock_lost, lock_near_loss, time_invalid, time_quality_fail};
      pin_sync_q <= pin_meta_q;
    end
  end

  logic hw_any;
  logic ps_any;
  logic [fao_pkg::N_DLY-1:0] raw_cond;

  always_comb
  begin
    hw_any   = |pin_sync_q[N_PIN-1 -: fao_pkg::HW_FAULT_W];
    ps_any   = |pin_sync_q[4 +: fao_pkg::N_PS];
    raw_cond = '0;
    raw_cond[fao_pkg::DLY_LOCK_ERR]  = pin_sync_q[3];
    raw_cond[fao_pkg::DLY_LOCK_WARN] = pin_sync_q[2];
    raw_cond[fao_pkg::DLY_TIME_ERR]  = pin_sync_q[1];
    raw_cond[fao_pkg::DLY_TIME_WARN] = pin_sync_q[0];
  end

  // ========================================================================
  // One-second time base
  logic [fao_pkg::SECCNT_W-1:0] sec_cnt_q;
  logic                         sec_tick_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sec_cnt_q  <= '0;
      sec_tick_q <= 1'b0;
    end
    else if (sec_cnt_q == fao_pkg::SECCNT_W'(SEC_CYCLES - 1))
    begin
      sec_cnt_q  <= '0;
      sec_tick_q <= 1'b1;
    end
    else
    begin
      sec_cnt_q  <= sec_cnt_q + fao_pkg::SECCNT_W'(1);
      sec_tick_q <= 1'b0;
    end
  end

  // ========================================================================
  // Register file
  logic [fao_pkg::N_SRC-1:0]  en_q [fao_pkg::N_OUT];
  logic [fao_pkg::TIME_W-1:0] dly_q [fao_pkg::N_DLY];
  logic [fao_pkg::TIME_W-1:0] alarm_tm_q;
  logic [fao_pkg::N_OUT-1:0]  irq_sts_q;
  logic [fao_pkg::N_OUT-1:0]  irq_mask_q;

  logic wr_fire;
  logic rd_fire;
  logic [fao_pkg::N_OUT-1:0] irq_clr;

  assign wr_fire = psel && penable && pready && pwrite;
  assign rd_fire = psel && penable && !pready;
  assign irq_clr = (wr_fire && paddr == fao_pkg::OFF_IRQ_STS) ? pwdata[fao_pkg::N_OUT-1:0] : '0;

  // Each output keeps its own enable word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < fao_pkg::N_OUT; i++)
        en_q[i] <= fao_pkg::RST_EN;
    end
    else if (wr_fire)
    begin
      if (paddr == fao_pkg::OFF_EN0)
        en_q[0] <= pwdata[fao_pkg::N_SRC-1:0];
      else if (paddr == fao_pkg::OFF_EN1)
        en_q[1] <= pwdata[fao_pkg::N_SRC-1:0];
      else if (paddr == fao_pkg::OFF_EN2)
        en_q[2] <= pwdata[fao_pkg::N_SRC-1:0];
    end
  end

  // Delays are shared, so a single word serves all three outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < fao_pkg::N_DLY; i++)
        dly_q[i] <= fao_pkg::RST_DLY;
    end
    else if (wr_fire)
    begin
      if (paddr == fao_pkg::OFF_DLY0)
        dly_q[0] <= pwdata[fao_pkg::TIME_W-1:0];
      else if (paddr == fao_pkg::OFF_DLY1)
        dly_q[1] <= pwdata[fao_pkg::TIME_W-1:0];
      else if (paddr == fao_pkg::OFF_DLY2)
        dly_q[2] <= pwdata[fao_pkg::TIME_W-1:0];
      else if (paddr == fao_pkg::OFF_DLY3)
        dly_q[3] <= pwdata[fao_pkg::TIME_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alarm_tm_q <= fao_pkg::RST_ALARM_TM;
      irq_mask_q <= fao_pkg::RST_MASK;
    end
    else if (wr_fire)
    begin
      if (paddr == fao_pkg::OFF_ALARM_TM)
        alarm_tm_q <= pwdata[fao_pkg::TIME_W-1:0];
      else if (paddr == fao_pkg::OFF_IRQ_MASK)
        irq_mask_q <= pwdata[fao_pkg::N_OUT-1:0];
    end
  end

  // ========================================================================
  // Delay qualifiers, one per delayed condition
  fao_dly_if dly_if [fao_pkg::N_DLY] ();
  logic [fao_pkg::N_DLY-1:0] qual_cond;

  for (genvar g = 0; g < fao_pkg::N_DLY; g++)
  begin : g_dly
    assign dly_if[g].cond      = raw_cond[g];
    assign dly_if[g].sec_tick  = sec_tick_q;
    assign dly_if[g].delay_hms = dly_q[g];
    assign qual_cond[g]        = dly_if[g].qual;

    fao_delay_qual u_qual
    (
      .pclk    (pclk),
      .presetn (presetn),
      .dly     (dly_if[g])
    );
  end

  // ========================================================================
  // Alarm time pulse
  logic                         tm_match_q;
  logic                         tm_pulse_q;
  logic [fao_pkg::SECCNT_W-1:0] tm_cnt_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tm_match_q <= 1'b0;
    else
      tm_match_q <= (program_time == alarm_tm_q);
  end

  // Starts on the first cycle of a match and lasts one second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tm_pulse_q <= 1'b0;
      tm_cnt_q   <= '0;
    end
    else if ((program_time == alarm_tm_q) && !tm_match_q)
    begin
      tm_pulse_q <= 1'b1;
      tm_cnt_q   <= fao_pkg::SECCNT_W'(SEC_CYCLES - 1);
    end
    else if (tm_cnt_q != '0)
      tm_cnt_q <= tm_cnt_q - fao_pkg::SECCNT_W'(1);
    else
      tm_pulse_q <= 1'b0;
  end

  // ========================================================================
  // Output mapping
  logic [fao_pkg::N_SRC-1:0] src_vec;
  logic [fao_pkg::N_OUT-1:0] alarm_d;
  logic [fao_pkg::N_OUT-1:0] alarm_q;

  always_comb
  begin
    src_vec = '0;
    src_vec[fao_pkg::SRC_HW]        = hw_any;
    src_vec[fao_pkg::SRC_PS]        = ps_any;
    src_vec[fao_pkg::SRC_LOCK_ERR]  = qual_cond[fao_pkg::DLY_LOCK_ERR];
    src_vec[fao_pkg::SRC_LOCK_WARN] = qual_cond[fao_pkg::DLY_LOCK_WARN];
    src_vec[fao_pkg::SRC_TIME_ERR]  = qual_cond[fao_pkg::DLY_TIME_ERR];
    src_vec[fao_pkg::SRC_TIME_WARN] = qual_cond[fao_pkg::DLY_TIME_WARN];
    src_vec[fao_pkg::SRC_ALARM_TM]  = tm_pulse_q;
    for (int i = 0; i < fao_pkg::N_OUT; i++)
      alarm_d[i] = |(src_vec & en_q[i]);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      alarm_q <= '0;
    else
      alarm_q <= alarm_d;
  end

  assign aux_alarm_port = alarm_q;

  // ========================================================================
  // Interrupts: an output rising sets its sticky bit, set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_sts_q <= '0;
    else
      irq_sts_q <= (irq_sts_q & ~irq_clr) | (alarm_d & ~alarm_q);
  end

  logic irq_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_q <= 1'b0;
    else
      irq_q <= |(((irq_sts_q & ~irq_clr) | (alarm_d & ~alarm_q)) & irq_mask_q);
  end

  assign irq = irq_q;

  // ========================================================================
  // APB answer: one wait state, ready raised for one cycle
  logic [31:0] rdata_d;
  logic        err_d;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  always_comb
  begin
    rdata_d = '0;
    err_d   = 1'b0;
    if (paddr == fao_pkg::OFF_EN0)
      rdata_d[fao_pkg::N_SRC-1:0] = en_q[0];
    else if (paddr == fao_pkg::OFF_EN1)
      rdata_d[fao_pkg::N_SRC-1:0] = en_q[1];
    else if (paddr == fao_pkg::OFF_EN2)
      rdata_d[fao_pkg::N_SRC-1:0] = en_q[2];
    else if (paddr == fao_pkg::OFF_DLY0)
      rdata_d[fao_pkg::TIME_W-1:0] = dly_q[0];
    else if (paddr == fao_pkg::OFF_DLY1)
      rdata_d[fao_pkg::TIME_W-1:0] = dly_q[1];
    else if (paddr == fao_pkg::OFF_DLY2)
      rdata_d[fao_pkg::TIME_W-1:0] = dly_q[2];
    else if (paddr == fao_pkg::OFF_DLY3)
      rdata_d[fao_pkg::TIME_W-1:0] = dly_q[3];
    else if (paddr == fao_pkg::OFF_ALARM_TM)
      rdata_d[fao_pkg::TIME_W-1:0] = alarm_tm_q;
    else if (paddr == fao_pkg::OFF_STATUS)
      rdata_d[18:0] = {alarm_q, raw_cond, qual_cond, 1'b0, src_vec};
    else if (paddr == fao_pkg::OFF_IRQ_STS)
      rdata_d[fao_pkg::N_OUT-1:0] = irq_sts_q;
    else if (paddr == fao_pkg::OFF_IRQ_MASK)
      rdata_d[fao_pkg::N_OUT-1:0] = irq_mask_q;
    else
      err_d = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end
    else
    begin
      pready_q  <= rd_fire;
      pslverr_q <= rd_fire && err_d;
      prdata_q  <= (rd_fire && !pwrite) ? rdata_d : '0;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

endmodule : fao_top

// [verif/fao_top_sva.sv]
// ==========================================
// Port-level checks of the alarm block
module fao_top_sva
#(
  parameter int unsigned SEC_CYCLES = 20
)
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  hw_fault,
  input wire logic [1:0]  ps_fault,
  input wire logic        lock_lost,
  input wire logic        lock_near_loss,
  input wire logic        time_invalid,
  input wire logic        time_quality_fail,
  input wire logic [23:0] program_time,
  input wire logic [2:0]  aux_alarm_port
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        cond_any;
  logic [31:0] quiet_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign cond_any = (|hw_fault) | (|ps_fault) | lock_near_loss | lock_lost | time_invalid | time_quality_fail;
  // A register write can start an alarm-time match, so it also restarts the quiet count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      quiet_q <= 32'h0;
    else if (cond_any || !$stable(program_time) || (psel && pwrite))
      quiet_q <= 32'h0;
    else
      quiet_q <= quiet_q + 32'h1;
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence wait_s;
    psel && penable && !pready;
  endsequence
  pready_timing_a: assert property (setup_s ##1 wait_s |=> pready) else $error("pready late");
  pready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  pready_cause_a: assert property (pready |-> psel && penable && $past(psel && penable)) else $error("stray pready");
  rdata_idle_a: assert property ((!pready || pwrite) |-> prdata == 32'h0) else $error("prdata not zero");
  err_pair_a: assert property (pslverr |-> pready) else $error("pslverr alone");
  unmapped_err_a: assert property (pready && paddr > 8'h28 |-> pslverr) else $error("no error");
  mapped_ok_a: assert property (pready && paddr <= 8'h28 && paddr[1:0] == 2'b00 |-> !pslverr) else $error("bad error");
  alarm_quiet_a: assert property (quiet_q > SEC_CYCLES + 8 |-> aux_alarm_port == 3'h0)
    else $error("alarm without cause");
endmodule : fao_top_sva

// [verif/fao_alarm_monitor.sv]
// ==========================================
// Monitoring equipment: measures each alarm pulse in clocks
module fao_alarm_monitor
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [2:0]       alarm,
  output logic      [2:0][15:0] pulse_len
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0][15:0] run_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_q <= '0;
      pulse_len <= '0;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        run_q[i] <= alarm[i] ? run_q[i] + 16'h1 : 16'h0;
        if (!alarm[i] && run_q[i] != 16'h0)
          pulse_len[i] <= run_q[i];
      end
    end
  end
endmodule : fao_alarm_monitor

// [verif/tb_top.sv]
// ==========================================
// Bench of the fault alarm block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned SEC = 20;
  logic             pclk;
  logic             presetn;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [7:0]       paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [7:0]       hw_fault;
  logic [1:0]       ps_fault;
  logic [3:0]       cond_v;
  logic [23:0]      program_time;
  logic [2:0]       aux_alarm_port;
  logic             irq;
  logic [2:0][15:0] pulse_len;
  logic [31:0]      rdat;
  logic             rerr;
  int               mismatches;
  int               comparisons;
  fao_top #(.SEC_CYCLES(SEC)) u_fao_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_fault(hw_fault), .ps_fault(ps_fault), .lock_lost(cond_v[0]), .lock_near_loss(cond_v[1]),
    .time_invalid(cond_v[2]), .time_quality_fail(cond_v[3]), .program_time(program_time),
    .aux_alarm_port(aux_alarm_port), .irq(irq));
  fao_alarm_monitor u_fao_alarm_monitor (.pclk(pclk), .presetn(presetn), .alarm(aux_alarm_port),
    .pulse_len(pulse_len));
  always #20 pclk = ~pclk;
  task end_sim;
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // Request held until the edge that samples pready high
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16)
    begin
      mismatches++;
      end_sim();
    end
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(a, 1'b0, 32'h0);
    chk("prdata", e, rdat);
    chk("pslverr", {31'h0, ee}, {31'h0, rerr});
  endtask : rd
  task s_regs;
    for (int i = 0; i < 11; i++)
      rd(8'(4 * i), (i >= 3 && i <= 6) ? 32'h10 : 32'h0, 1'b0);
    wr(fao_pkg::OFF_DLY3, 32'hff235959);
    rd(fao_pkg::OFF_DLY3, 32'h00235959, 1'b0);
    wr(fao_pkg::OFF_STATUS, 32'hffffffff);
    rd(fao_pkg::OFF_STATUS, 32'h0, 1'b0);
    rd(8'h2c, 32'h0, 1'b1);
    wr(8'hfc, 32'h1);
    chk("wr pslverr", 32'h1, {31'h0, rerr});
  endtask : s_regs
  task s_direct;
    wr(fao_pkg::OFF_EN0, 32'h05);
    wr(fao_pkg::OFF_EN1, 32'h42);
    wr(fao_pkg::OFF_EN2, 32'h3c);
    hw_fault <= 8'h20;
    cyc(5);
    chk("hw alarm", 32'h1, {29'h0, aux_alarm_port});
    hw_fault <= 8'h00;
    ps_fault <= 2'b10;
    cyc(6);
    chk("ps alarm", 32'h2, {29'h0, aux_alarm_port});
    ps_fault <= 2'b00;
    cyc(6);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(fao_pkg::OFF_IRQ_STS, 32'h3, 1'b0);
    wr(fao_pkg::OFF_IRQ_MASK, 32'h2);
    cyc(3);
    chk("irq set", 32'h1, {31'h0, irq});
    wr(fao_pkg::OFF_IRQ_STS, 32'h2);
    cyc(3);
    chk("irq clear", 32'h0, {31'h0, irq});
    rd(fao_pkg::OFF_IRQ_STS, 32'h1, 1'b0);
  endtask : s_direct
  // Two second delays; a first episode shorter than the delay must leave no credit behind
  task s_delay;
    logic [31:0] e;
    for (int k = 0; k < 4; k++)
      wr(8'(fao_pkg::OFF_DLY0 + 4 * k), 32'h2);
    for (int k = 0; k < 4; k++)
    begin
      e = (k == 0) ? 32'h5 : 32'h4;
      cond_v <= 4'(1 << k);
      cyc(SEC * 3 / 2);
      chk("early", 32'h0, {29'h0, aux_alarm_port});
      cond_v <= 4'h0;
      cyc(8);
      cond_v <= 4'(1 << k);
      cyc(SEC * 3 / 2);
      chk("restart", 32'h0, {29'h0, aux_alarm_port});
      cyc(SEC * 2);
      chk("delayed", e, {29'h0, aux_alarm_port});
      // Outputs, raw and qualified condition, and source vector all show the one condition
      rd(fao_pkg::OFF_STATUS, (e << 16) | (32'h1100 << k) | (32'h4 << k), 1'b0);
      cond_v <= 4'h0;
      cyc(6);
      chk("cleared", 32'h0, {29'h0, aux_alarm_port});
    end
    wr(fao_pkg::OFF_DLY2, 32'h100);
    cond_v <= 4'h4;
    cyc(SEC * 58);
    chk("minute early", 32'h0, {29'h0, aux_alarm_port});
    cyc(SEC * 3 + 10);
    chk("minute", 32'h4, {29'h0, aux_alarm_port});
    cond_v <= 4'h0;
    cyc(6);
  endtask : s_delay
  task s_alarm;
    wr(fao_pkg::OFF_ALARM_TM, 32'h123000);
    cyc(4);
    program_time <= 24'h123000;
    cyc(6);
    chk("alarm on", 32'h2, {29'h0, aux_alarm_port});
    cyc(SEC + 10);
    chk("alarm len", SEC, {16'h0, pulse_len[1]});
    program_time <= 24'h000000;
    cyc(SEC * 3);
  endtask : s_alarm
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hw_fault = 8'h00;
    ps_fault = 2'b00;
    cond_v = 4'h0;
    program_time = 24'h000000;
    mismatches = 0;
    comparisons = 0;
    cyc(16);
    presetn <= 1'b1;
    cyc(SEC * 2);
    chk("idle alarm", 32'h0, {29'h0, aux_alarm_port});
    s_regs();
    s_direct();
    s_delay();
    s_alarm();
    end_sim();
  end
endmodule : tb_top
bind fao_top fao_top_sva #(.SEC_CYCLES(SEC_CYCLES)) u_fao_top_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .hw_fault(hw_fault), .ps_fault(ps_fault),
  .lock_lost(lock_lost), .lock_near_loss(lock_near_loss), .time_invalid(time_invalid),
  .time_quality_fail(time_quality_fail), .program_time(program_time), .aux_alarm_port(aux_alarm_port));
